// >>> verilog/sdram_cmd_pkg.sv
package sdram_cmd_pkg;
   // ---------------------------------------------------------------
   // Geometry
   // ---------------------------------------------------------------
   localparam int NUM_BANKS = 4;
   localparam int ROW_W     = 12;
   localparam int ADDR_W    = 12;
   localparam int AP_BIT    = 10;
   localparam int ROWS      = 4096;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_PS      = 100000;
   localparam int WRITE_RECOVERY_PS  = 7500;
   localparam int WR_EXTRA_CYC       = (WRITE_RECOVERY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WRITE_RECOVERY_CYC = 1 + WR_EXTRA_CYC;
   localparam int MASK_READ_DELAY    = 2;
   localparam int CAS_LATENCY        = 2;
   // ---------------------------------------------------------------
   // Mode op-code fields: burst length code in bits 2..0
   // ---------------------------------------------------------------
   localparam int          BL_LSB      = 0;
   localparam int          BT_BIT      = 3;
   localparam logic [11:0] MODE_RESET  = 12'h022;
   localparam logic [2:0]  BL_FULLPAGE = 3'h7;
   // Decoded commands: {ras_n, cas_n, we_n}
   typedef enum logic [2:0] {
      CMD_MODE  = 3'h0,
      CMD_REF   = 3'h1,
      CMD_PRE   = 3'h2,
      CMD_ACT   = 3'h3,
      CMD_WRITE = 3'h4,
      CMD_READ  = 3'h5,
      CMD_STOP  = 3'h6,
      CMD_NOP   = 3'h7
   } cmd_t;
   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_READ  = 4'h2,
      ST_WRITE = 4'h4,
      ST_SELF  = 4'h8
   } state_t;
endpackage

// >>> verilog/wdata_if.sv
`timescale 1ns/1ps
// Write stream between the decoder and its FIFO
interface wdata_if #(parameter int W = 32);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport dst (input valid, input data, output ready);
endinterface

// >>> verilog/stream_fifo.sv
`timescale 1ns/1ps
module stream_fifo #(
   parameter int W     = 32,
   parameter int DEPTH = 32
) (
   input  wire logic         core_clk,
   input  wire logic         rst,
   input  wire logic         ce,
   wdata_if.dst              in_s,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wp_q, rp_q;
   logic [AW:0]   cnt_q;
   wire           push = in_s.valid && in_s.ready && ce;
   wire           pop  = out_valid && out_ready && ce;
   // Full and empty from the occupancy count; one spare count bit tells full from empty
   assign in_s.ready = (cnt_q < (AW+1)'(DEPTH));
   assign out_valid  = (cnt_q != '0);
   assign out_data   = mem_q[rp_q];
   // Pointer and count update
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else if (ce) begin
         if (push) begin
            mem_q[wp_q] <= in_s.data;
            wp_q        <= wp_q + 1'b1;
         end
         if (pop) rp_q <= rp_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// >>> verilog/bank_tracker.sv
`timescale 1ns/1ps
// One entry per bank: open flag and open row
module bank_tracker #(
   parameter int NB = 4,
   parameter int RW = 12
) (
   input  wire logic                  core_clk,
   input  wire logic                  rst,
   input  wire logic                  ce,
   input  wire logic                  act,
   input  wire logic [1:0]            bank,
   input  wire logic [RW-1:0]         row,
   input  wire logic [NB-1:0]         close,
   output logic      [NB-1:0]         open_q,
   output logic      [NB*RW-1:0]      rows_q
);
   for (genvar b = 0; b < NB; b++) begin : g_bank
      wire sel = act && (bank == 2'(b));
      // A close on an opening bank loses: the activate is newer
      always_ff @(posedge core_clk) begin
         if (rst) begin
            open_q[b]            <= 1'b0;
            rows_q[b*RW +: RW]   <= '0;
         end else if (ce) begin
            if (sel) begin
               open_q[b]          <= 1'b1;
               rows_q[b*RW +: RW] <= row;
            end else if (close[b]) begin
               open_q[b]          <= 1'b0;
            end
         end
      end
   end
endmodule

// >>> verilog/sdram_cmd_decoder.sv
`timescale 1ns/1ps
module sdram_cmd_decoder #(
   parameter int DQ_W   = 16,
   parameter int COL_W  = 8,
   parameter int FIFO_D = 32
) (
   input  wire logic                core_clk,
   input  wire logic                rst,
   input  wire logic                ce,
   input  wire logic                cke,
   input  wire logic                cs_n,
   input  wire logic                ras_n,
   input  wire logic                cas_n,
   input  wire logic                we_n,
   input  wire logic                bank_select_lo,
   input  wire logic                bank_select_hi,
   input  wire logic [11:0]         addr,
   input  wire logic [DQ_W/8-1:0]   dqm,
   input  wire logic [DQ_W-1:0]     dq_in,
   output logic      [DQ_W-1:0]     dq_out,
   output logic      [DQ_W-1:0]     dq_oe,
   input  wire logic [DQ_W-1:0]     rd_data,
   output logic      [COL_W-1:0]    array_col,
   output logic      [1:0]          array_bank,
   output logic      [11:0]         array_row,
   output logic                     wr_valid,
   input  wire logic                wr_ready,
   output logic      [DQ_W+DQ_W/8+2+12+COL_W-1:0] wr_word,
   output logic                     refresh_pulse,
   output logic      [11:0]         refresh_row,
   output logic                     self_refresh,
   output logic      [11:0]         mode_q,
   output logic      [3:0]          bank_open,
   output logic                     precharging
);
   localparam int NBY = DQ_W / 8;
   localparam int WW  = DQ_W + NBY + 2 + 12 + COL_W;
   // ---------------------------------------------------------------
   // Command decode
   // ---------------------------------------------------------------
   sdram_cmd_pkg::state_t st_q, st_d;
   // Inputs are used only on clock edges; chip select high blocks all
   wire                           sel     = ~cs_n;
   wire sdram_cmd_pkg::cmd_t      cmd     = sdram_cmd_pkg::cmd_t'({ras_n, cas_n, we_n});
   wire [1:0]                     bank    = {bank_select_hi, bank_select_lo};
   wire                           auto_precharge_bit = addr[sdram_cmd_pkg::AP_BIT];
   wire                           run     = ce && st_q != sdram_cmd_pkg::ST_SELF;
   wire                           go      = run && sel && cke;
   wire                           is_act  = go && cmd == sdram_cmd_pkg::CMD_ACT;
   wire                           is_rd   = go && cmd == sdram_cmd_pkg::CMD_READ;
   wire                           is_wr   = go && cmd == sdram_cmd_pkg::CMD_WRITE;
   wire                           is_stop = go && cmd == sdram_cmd_pkg::CMD_STOP;
   wire                           is_pre  = go && cmd == sdram_cmd_pkg::CMD_PRE;
   wire                           is_mode = go && cmd == sdram_cmd_pkg::CMD_MODE;
   wire                           is_ref  = run && sel && cmd == sdram_cmd_pkg::CMD_REF;
   // ---------------------------------------------------------------
   // State and burst registers
   // ---------------------------------------------------------------
   logic [COL_W-1:0] start_q, ofs_q;
   logic [COL_W-1:0] left_q;
   logic [1:0]       bb_q;
   logic             ap_q;
   logic [11:0]      ref_ctr_q;
   logic [3:0]       wr_cnt_q;
   logic [1:0]       wr_bank_q;
   logic             wr_ap_q;
   logic [3:0]       close_v;
   logic [NBY-1:0]   mask_pipe_q [sdram_cmd_pkg::MASK_READ_DELAY];
   logic [sdram_cmd_pkg::CAS_LATENCY-1:0] rvalid_pipe_q;
   logic [11:0]      bank_rows [4];
   logic [4*12-1:0]  rows_flat;
   // Burst length from the mode op-code; full page runs the whole row
   wire [2:0]        bl_code = mode_q[sdram_cmd_pkg::BL_LSB +: 3];
   wire              il_mode = mode_q[sdram_cmd_pkg::BT_BIT];
   wire [COL_W-1:0]  bl_m1   = (bl_code == sdram_cmd_pkg::BL_FULLPAGE) ? {COL_W{1'b1}} :
                               COL_W'((4'h1 << bl_code[1:0]) - 4'h1);
   wire              in_burst = st_q == sdram_cmd_pkg::ST_READ || st_q == sdram_cmd_pkg::ST_WRITE;
   wire              last     = in_burst && left_q == '0;
   wire              ended    = (last && ce) || is_stop;
   wire [COL_W-1:0]  ofs_n    = ofs_q + 1'b1;
   // Sequential wraps inside the burst block, interleaved xors the offset
   wire [COL_W-1:0]  cur_col  = il_mode ? (start_q ^ ofs_q) :
                                ((start_q & ~bl_m1) | ((start_q + ofs_q) & bl_m1));
   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      case (st_q)
         sdram_cmd_pkg::ST_IDLE, sdram_cmd_pkg::ST_READ, sdram_cmd_pkg::ST_WRITE: begin
            if (is_ref && !cke)  st_d = sdram_cmd_pkg::ST_SELF;
            else if (is_rd)      st_d = sdram_cmd_pkg::ST_READ;
            else if (is_wr)      st_d = sdram_cmd_pkg::ST_WRITE;
            else if (ended)      st_d = sdram_cmd_pkg::ST_IDLE;
         end
         sdram_cmd_pkg::ST_SELF: begin
            // Exit on clock-gate high; controller holds off for the exit wait
            if (cke) st_d = sdram_cmd_pkg::ST_IDLE;
         end
         default: st_d = sdram_cmd_pkg::ST_IDLE;
      endcase
   end
   // State register; frozen with the rest while the clock enable is low
   always_ff @(posedge core_clk) begin
      if (rst) st_q <= sdram_cmd_pkg::ST_IDLE;
      else if (ce) st_q <= st_d;
   end
   // ---------------------------------------------------------------
   // Burst address sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         start_q <= '0;
         ofs_q   <= '0;
         left_q  <= '0;
         bb_q    <= '0;
         ap_q    <= 1'b0;
      end else if (ce) begin
         if (is_rd || is_wr) begin
            start_q <= addr[COL_W-1:0];
            ofs_q   <= '0;
            left_q  <= bl_m1;
            bb_q    <= bank;
            ap_q    <= auto_precharge_bit;
         end else if (in_burst && cke) begin
            ofs_q  <= ofs_n;
            left_q <= left_q - 1'b1;
         end
      end
   end
   // ---------------------------------------------------------------
   // Write recovery then auto precharge of the written bank
   // ---------------------------------------------------------------
   wire wr_ap_end = st_q == sdram_cmd_pkg::ST_WRITE && ap_q && ended && !is_stop;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wr_cnt_q  <= '0;
         wr_bank_q <= '0;
         wr_ap_q   <= 1'b0;
      end else if (ce) begin
         if (wr_ap_end) begin
            wr_cnt_q  <= 4'(sdram_cmd_pkg::WRITE_RECOVERY_CYC);
            wr_bank_q <= bb_q;
            wr_ap_q   <= 1'b1;
         end else if (wr_cnt_q != '0) begin
            wr_cnt_q <= wr_cnt_q - 1'b1;
         end else begin
            wr_ap_q <= 1'b0;
         end
      end
   end
   assign precharging = wr_ap_q;
   // Per-bank close vector: explicit precharge, read auto precharge, write recovery end
   for (genvar b = 0; b < 4; b++) begin : g_close
      assign close_v[b] = (is_pre && (auto_precharge_bit || bank == 2'(b)))
                        | (st_q == sdram_cmd_pkg::ST_READ && ap_q && ended && bb_q == 2'(b))
                        | (wr_ap_q && wr_cnt_q == '0 && wr_bank_q == 2'(b));
      assign bank_rows[b] = rows_flat[b*12 +: 12];
   end
   bank_tracker #(
      .NB (4),
      .RW (12)
   ) u_banks (
      .core_clk (core_clk),
      .rst      (rst),
      .ce       (ce),
      .act      (is_act),
      .bank     (bank),
      .row      (addr[sdram_cmd_pkg::ROW_W-1:0]),
      .close    (close_v),
      .open_q   (bank_open),
      .rows_q   (rows_flat)
   );
   // ---------------------------------------------------------------
   // Mode register and refresh counter
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         mode_q        <= sdram_cmd_pkg::MODE_RESET;
         ref_ctr_q     <= '0;
         refresh_pulse <= 1'b0;
      end else if (ce) begin
         refresh_pulse <= is_ref;
         if (is_mode) mode_q <= addr;
         if (is_ref) ref_ctr_q <= ref_ctr_q + 1'b1;
      end
   end
   assign refresh_row  = ref_ctr_q;
   assign self_refresh = st_q == sdram_cmd_pkg::ST_SELF;
   // ---------------------------------------------------------------
   // Array address for the current beat
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         array_col  <= '0;
         array_bank <= '0;
         array_row  <= '0;
      end else if (ce) begin
         array_col  <= cur_col;
         array_bank <= bb_q;
         array_row  <= bank_rows[bb_q];
      end
   end
   // ---------------------------------------------------------------
   // Write path into the FIFO: data, mask, address
   // ---------------------------------------------------------------
   // Mask is taken with the coincident beat, not delayed. The command cycle carries beat 0,
   // so each later burst cycle carries the next offset and the final one carries none
   wire wbeat = ce && cke && st_q == sdram_cmd_pkg::ST_WRITE && !last && !is_stop;
   wire wfirst = is_wr;
   wire [COL_W-1:0] nxt_col = il_mode ? (start_q ^ ofs_n) :
                              ((start_q & ~bl_m1) | ((start_q + ofs_n) & bl_m1));
   wdata_if #(.W(WW)) wq ();
   assign wq.valid = (wbeat || wfirst) && ~&dqm;
   assign wq.data  = {dq_in, dqm, (wfirst ? bank : bb_q), (wfirst ? bank_rows[bank] : bank_rows[bb_q]),
                      (wfirst ? addr[COL_W-1:0] : nxt_col)};
   stream_fifo #(
      .W     (WW),
      .DEPTH (FIFO_D)
   ) u_fifo (
      .core_clk  (core_clk),
      .rst       (rst),
      .ce        (ce),
      .in_s      (wq),
      .out_valid (wr_valid),
      .out_ready (wr_ready),
      .out_data  (wr_word)
   );
   // ---------------------------------------------------------------
   // Read data drive with two-clock mask delay
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int i = 0; i < sdram_cmd_pkg::MASK_READ_DELAY; i++) mask_pipe_q[i] <= '1;
         rvalid_pipe_q <= '0;
         dq_out        <= '0;
         dq_oe         <= '0;
      end else if (ce) begin
         mask_pipe_q[0] <= dqm;
         for (int i = 1; i < sdram_cmd_pkg::MASK_READ_DELAY; i++) mask_pipe_q[i] <= mask_pipe_q[i-1];
         rvalid_pipe_q <= {rvalid_pipe_q[sdram_cmd_pkg::CAS_LATENCY-2:0],
                           (is_rd || (st_q == sdram_cmd_pkg::ST_READ && !ended))};
         dq_out <= rd_data;
         for (int k = 0; k < NBY; k++)
            dq_oe[k*8 +: 8] <= {8{rvalid_pipe_q[sdram_cmd_pkg::CAS_LATENCY-1] &&
                                   !mask_pipe_q[sdram_cmd_pkg::MASK_READ_DELAY-1][k]}};
      end
   end
endmodule

// >>> testbench/sdram_cmd_checker_sva.sv
`timescale 1ns/1ps
module sdram_cmd_checker #(parameter int DQ_W = 16) (
   input wire logic              core_clk,
   input wire logic              rst,
   input wire logic              ce,
   input wire logic              cke,
   input wire logic              cs_n,
   input wire logic              ras_n,
   input wire logic              cas_n,
   input wire logic              we_n,
   input wire logic              bank_select_lo,
   input wire logic              bank_select_hi,
   input wire logic [11:0]       addr,
   input wire logic [DQ_W/8-1:0] dqm,
   input wire logic [DQ_W-1:0]   dq_oe,
   input wire logic              refresh_pulse,
   input wire logic              self_refresh,
   input wire logic [11:0]       mode_q,
   input wire logic [3:0]        bank_open
);
   // ---------------------------------------------------------------
   // Command decode as seen on the pins
   // ---------------------------------------------------------------
   wire       taken_w = ce && !cs_n && cke && !self_refresh;
   wire [2:0] code_w  = {ras_n, cas_n, we_n};
   wire [1:0] bank_w  = {bank_select_hi, bank_select_lo};
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   act_opens_a: assert property (taken_w && code_w == 3'h3 |=> bank_open[$past(bank_w)])
      else $error("activate did not open its bank");
   bank_hold_a: assert property (!(taken_w && code_w == 3'h3) |=> (bank_open & ~$past(bank_open)) == 4'h0)
      else $error("bank opened without an activate");
   mode_load_a: assert property (taken_w && code_w == 3'h0 |=> mode_q == $past(addr))
      else $error("mode register not loaded from address");
   mode_hold_a: assert property (!(taken_w && code_w == 3'h0) |=> $stable(mode_q))
      else $error("mode register changed without a load");
   pre_all_a: assert property (taken_w && code_w == 3'h2 && addr[10] |=> bank_open == 4'h0)
      else $error("precharge all left a bank open");
   pre_one_a: assert property (taken_w && code_w == 3'h2 && !addr[10] |=> !bank_open[$past(bank_w)])
      else $error("precharge left its bank open");
   ref_pulse_a: assert property (taken_w && code_w == 3'h1 |=> refresh_pulse)
      else $error("auto refresh gave no pulse");
   pulse_once_a: assert property (refresh_pulse && !self_refresh |=> !refresh_pulse)
      else $error("refresh pulse longer than one cycle");
   self_ref_a: assert property (ce && !cs_n && !self_refresh && !cke && code_w == 3'h1 |=> self_refresh)
      else $error("self refresh not entered");
   read_mask_a: assert property (ce && dqm[0] |-> ##3 dq_oe[7:0] == 8'h00)
      else $error("masked byte was driven");
   // Main scenarios reached
   cov_write: cover property (taken_w && code_w == 3'h4);
   cov_read: cover property (taken_w && code_w == 3'h5);
   cov_self: cover property ($rose(self_refresh));
endmodule
bind sdram_cmd_decoder sdram_cmd_checker #(.DQ_W(DQ_W)) i_sdram_cmd_checker (
   .core_clk(core_clk), .rst(rst), .ce(ce), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
   .we_n(we_n), .bank_select_lo(bank_select_lo), .bank_select_hi(bank_select_hi), .addr(addr),
   .dqm(dqm), .dq_oe(dq_oe), .refresh_pulse(refresh_pulse), .self_refresh(self_refresh),
   .mode_q(mode_q), .bank_open(bank_open));

// >>> testbench/mem_array_model.sv
`timescale 1ns/1ps
module mem_array_model (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic [1:0]  array_bank,
   input  wire logic [11:0] array_row,
   input  wire logic [7:0]  array_col,
   output logic      [15:0] rd_data,
   input  wire logic        wr_valid,
   output logic             wr_ready,
   input  wire logic [39:0] wr_word,
   input  wire logic        stall,
   output int               n_words,
   output logic      [39:0] last_word
);
   logic slow_q;
   // Read data is a fingerprint of the addressed cell, so a wrong address shows
   assign rd_data  = {array_bank, array_row[5:0], array_col};
   // Accepts only every other cycle, never while stalled: a slow sink
   assign wr_ready = !stall && slow_q;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         slow_q  <= 1'b0;
         n_words <= 0;
      end else begin
         slow_q <= !slow_q;
         if (wr_valid && wr_ready) begin
            n_words   <= n_words + 1;
            last_word <= wr_word;
         end
      end
   end
endmodule

// >>> testbench/tb.sv
`timescale 1ns/1ps
module tb;
   logic core_clk, rst, ce, cke, cs_n, ras_n, cas_n, we_n, bank_select_lo, bank_select_hi, stall;
   logic [11:0] addr, refresh_row, mode_q, array_row, row0;
   logic [1:0]  dqm, array_bank;
   logic [15:0] dq_in, dq_out, dq_oe, rd_data;
   logic [7:0]  array_col;
   logic [39:0] wr_word, last_word;
   logic [3:0]  bank_open;
   logic        wr_valid, wr_ready, refresh_pulse, self_refresh, precharging;
   int          err_count, n_tests, n_words, i, n0;

   sdram_cmd_decoder i_sdram_cmd_decoder (.core_clk(core_clk), .rst(rst), .ce(ce), .cke(cke), .cs_n(cs_n),
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_select_lo(bank_select_lo),
      .bank_select_hi(bank_select_hi), .addr(addr), .dqm(dqm), .dq_in(dq_in), .dq_out(dq_out),
      .dq_oe(dq_oe), .rd_data(rd_data), .array_col(array_col), .array_bank(array_bank),
      .array_row(array_row), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word),
      .refresh_pulse(refresh_pulse), .refresh_row(refresh_row), .self_refresh(self_refresh),
      .mode_q(mode_q), .bank_open(bank_open), .precharging(precharging));
   mem_array_model i_mem_array_model (.core_clk(core_clk), .rst(rst), .array_bank(array_bank),
      .array_row(array_row), .array_col(array_col), .rd_data(rd_data), .wr_valid(wr_valid),
      .wr_ready(wr_ready), .wr_word(wr_word), .stall(stall), .n_words(n_words), .last_word(last_word));

   // Clock: 100 ns period
   always #50 core_clk = !core_clk;

   // ---------------------------------------------------------------
   // Bench tasks
   // ---------------------------------------------------------------
   task automatic end_sim();
      $display("tests %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t %s: got %0h expected %0h", $time, what, got, exp);
      end
   endtask
   // A wait that used up its bound ends the run
   task automatic lim(input int k, input int max);
      if (k >= max) begin
         err_count++;
         $display("ERROR %0t wait ran out", $time);
         end_sim();
      end
   endtask
   // One command at a falling edge, then a NOP, so commands sit two cycles apart
   task automatic cmd(input logic sel_n, input sdram_cmd_pkg::cmd_t c, input logic [1:0] b, input logic [11:0] a);
      @(negedge core_clk);
      cs_n = sel_n;
      {ras_n, cas_n, we_n} = c;
      {bank_select_hi, bank_select_lo} = b;
      addr = a;
      @(negedge core_clk);
      cs_n = 1'b0;
      {ras_n, cas_n, we_n} = 3'h7;
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      core_clk = 0; rst = 1; ce = 1; cke = 1; cs_n = 1; ras_n = 1; cas_n = 1; we_n = 1; stall = 0;
      bank_select_lo = 0; bank_select_hi = 0; addr = 12'h000; dqm = 2'h0; dq_in = 16'h0000;
      err_count = 0; n_tests = 0;
      repeat (8) @(negedge core_clk);
      rst = 0;
      chk(mode_q, 12'h022, "mode after reset");
      chk(bank_open, 4'h0, "banks after reset");
      // Power-up: two auto refreshes, address and bank ignored
      repeat (2) begin
         row0 = refresh_row;
         cmd(1'b0, sdram_cmd_pkg::CMD_REF, 2'h3, 12'hFFF);
         chk(refresh_pulse, 1'b1, "refresh pulse");
         chk(bank_open, 4'h0, "refresh opened a bank");
         @(negedge core_clk);
         chk(refresh_row, row0 + 12'h001, "refresh row step");
      end
      // Mode load for single beats, then one while deselected
      cmd(1'b0, sdram_cmd_pkg::CMD_MODE, 2'h0, 12'h020);
      chk(mode_q, 12'h020, "mode load");
      cmd(1'b1, sdram_cmd_pkg::CMD_MODE, 2'h0, 12'h0AA);
      chk(mode_q, 12'h020, "deselected load");
      // Open every bank, close one, then all
      for (i = 0; i < 4; i++) begin
         cmd(1'b0, sdram_cmd_pkg::CMD_ACT, 2'(i), 12'h100 + 12'(i));
         chk(bank_open[i], 1'b1, "activate");
      end
      cmd(1'b0, sdram_cmd_pkg::CMD_PRE, 2'h1, 12'h000);
      chk(bank_open, 4'hD, "precharge one");
      cmd(1'b0, sdram_cmd_pkg::CMD_PRE, 2'h1, 12'h400);
      chk(bank_open, 4'h0, "precharge all");
      // Write one beat; high column bits must not reach the column
      cmd(1'b0, sdram_cmd_pkg::CMD_ACT, 2'h2, 12'h5A5);
      n0 = n_words;
      dq_in = 16'hBEEF;
      cmd(1'b0, sdram_cmd_pkg::CMD_WRITE, 2'h2, 12'h312);
      for (i = 0; i < 20 && n_words == n0; i++) @(negedge core_clk);
      lim(i, 20);
      chk(last_word, {16'hBEEF, 2'h0, 2'h2, 12'h5A5, 8'h12}, "write word");
      // Fully masked write is not executed
      dqm = 2'h3;
      dq_in = 16'h1111;
      cmd(1'b0, sdram_cmd_pkg::CMD_WRITE, 2'h2, 12'h013);
      dqm = 2'h0;
      repeat (8) @(negedge core_clk);
      chk(n_words, n0 + 1, "masked write");
      chk(bank_open[2], 1'b1, "row left open");
      // Read one beat
      cmd(1'b0, sdram_cmd_pkg::CMD_READ, 2'h2, 12'h034);
      for (i = 0; i < 8 && dq_oe == 16'h0000; i++) @(negedge core_clk);
      lim(i, 8);
      chk(dq_oe, 16'hFFFF, "read enable");
      chk(dq_out, {2'h2, 6'h25, 8'h34}, "read data");
      // Masked read keeps the pins floating
      repeat (4) @(negedge core_clk);
      dqm = 2'h3;
      cmd(1'b0, sdram_cmd_pkg::CMD_READ, 2'h2, 12'h035);
      for (i = 0; i < 6; i++) begin
         @(negedge core_clk);
         chk(dq_oe, 16'h0000, "masked read");
      end
      dqm = 2'h0;
      // Write with auto precharge closes the bank after the burst
      dq_in = 16'h7E57;
      cmd(1'b0, sdram_cmd_pkg::CMD_WRITE, 2'h2, 12'h412);
      @(negedge core_clk);
      chk(precharging, 1'b1, "write recovery running");
      for (i = 0; i < 8 && bank_open[2]; i++) @(negedge core_clk);
      lim(i, 8);
      chk(bank_open, 4'h0, "auto precharge");
      // Self refresh: commands ignored until the clock gate rises
      cke = 0;
      cmd(1'b0, sdram_cmd_pkg::CMD_REF, 2'h0, 12'h000);
      chk(self_refresh, 1'b1, "self refresh entry");
      cmd(1'b0, sdram_cmd_pkg::CMD_ACT, 2'h0, 12'h001);
      chk(bank_open, 4'h0, "ignored in self refresh");
      cke = 1;
      for (i = 0; i < 8 && self_refresh; i++) @(negedge core_clk);
      lim(i, 8);
      repeat (2) @(negedge core_clk);
      // Interleaved burst of four: columns run 35, 34, 37, 36
      cmd(1'b0, sdram_cmd_pkg::CMD_MODE, 2'h0, 12'h00A);
      cmd(1'b0, sdram_cmd_pkg::CMD_ACT, 2'h1, 12'h3C1);
      cmd(1'b0, sdram_cmd_pkg::CMD_READ, 2'h1, 12'h035);
      for (i = 0; i < 8 && dq_oe == 16'h0000; i++) @(negedge core_clk);
      lim(i, 8);
      for (i = 0; i < 4; i++) begin
         chk(dq_out, {2'h1, 6'h01, 8'h35 ^ 8'(i)}, "interleaved beat");
         @(negedge core_clk);
      end
      cmd(1'b0, sdram_cmd_pkg::CMD_PRE, 2'h1, 12'h000);
      // Full-page write into a stalled sink, then terminate and drain
      cmd(1'b0, sdram_cmd_pkg::CMD_MODE, 2'h0, 12'h027);
      cmd(1'b0, sdram_cmd_pkg::CMD_ACT, 2'h3, 12'h0F0);
      stall = 1;
      n0 = n_words;
      cmd(1'b0, sdram_cmd_pkg::CMD_WRITE, 2'h3, 12'h000);
      for (i = 0; i < 40; i++) begin
         @(negedge core_clk);
         dq_in = 16'(i);
      end
      cmd(1'b0, sdram_cmd_pkg::CMD_STOP, 2'h0, 12'h000);
      chk(wr_valid, 1'b1, "buffer held while stalled");
      chk(n_words, n0, "no word while stalled");
      stall = 0;
      for (i = 0; i < 400 && wr_valid; i++) @(negedge core_clk);
      lim(i, 400);
      chk(wr_valid, 1'b0, "buffer drained");
      chk(bank_open[3], 1'b1, "terminate keeps row");
      end_sim();
   end
endmodule
